// *** include/slgw_led_if.sv ***
// slgw_led_if: carries link state into the activity blinker and its led level back
// assumes both ends run on the same system clock
`timescale 1ns/1ps
interface slgw_led_if;
	logic link_up;
	logic activity;
	logic led_off;
	modport ctrl (output link_up, output activity, input led_off);
	modport blink (input link_up, input activity, output led_off);
endinterface

// *** include/slgw_pkg.sv ***
// slgw_pkg: register map, field positions, reset values and timing constants
// assumes a 200 MHz system clock and a 32-bit apb register bus
package slgw_pkg;

	// ************************************************************
	// register byte offsets
	// ************************************************************
	localparam logic [7:0] ADDR_GPIO_CFG   = 8'h00;
	localparam logic [7:0] ADDR_GPIO_DATA  = 8'h04;
	localparam logic [7:0] ADDR_WAKE_CFG   = 8'h08;
	localparam logic [7:0] ADDR_PWR_CTRL   = 8'h0C;
	localparam logic [7:0] ADDR_BYTE_TEST  = 8'h10;
	localparam logic [7:0] ADDR_IRQ_STATUS = 8'h14;
	localparam logic [7:0] ADDR_IRQ_MASK   = 8'h18;
	localparam logic [7:0] ADDR_LINK_STAT  = 8'h1C;

	// ************************************************************
	// field positions
	// ************************************************************
	// gpio_cfg: [2:0] output enable, [6:4] open-drain select, [10:8] led function
	localparam int GPIO_OE_LSB  = 0;
	localparam int GPIO_OD_LSB  = 4;
	localparam int GPIO_LED_LSB = 8;
	// wake_cfg
	localparam int WAKE_EN_BIT  = 0;
	localparam int WAKE_POL_BIT = 1;
	localparam int WAKE_OD_BIT  = 2;
	localparam int WAKE_CLR_BIT = 3;
	// pwr_ctrl
	localparam int PWR_SLEEP_BIT = 0;
	localparam int PWR_SOFT_RESET_CMD_BIT  = 1;
	// irq status bits
	localparam int IRQ_WAKE_BIT    = 0;
	localparam int IRQ_LINK_BIT    = 1;
	localparam int IRQ_WDROP_BIT   = 2;
	localparam int IRQ_W           = 3;
	// link status read
	localparam int LS_LINK_BIT   = 0;
	localparam int LS_SPD_BIT    = 1;
	localparam int LS_FDX_BIT    = 2;
	localparam int LS_ANEG_BIT   = 3;
	localparam int LS_XOVER_BIT  = 4;
	localparam int LS_ARMED_BIT  = 5;
	localparam int LS_ASLEEP_BIT = 6;

	localparam int GPIO_N = 3;
	localparam logic [31:0] BYTE_TEST_VALUE = 32'h87654321;
	localparam logic [31:0] REG_ZERO        = 32'h00000000;

	// ************************************************************
	// timing
	// ************************************************************
	localparam longint CLK_HZ        = 200000000;
	localparam longint LED_PULSE_MS  = 80;
	localparam longint LED_PULSE_CYC = (CLK_HZ * LED_PULSE_MS) / 1000;
	localparam int     LED_CNT_W     = 24;

	typedef enum logic [2:0] {
		SLGW_ACT_IDLE = 3'b001,
		SLGW_ACT_OFF  = 3'b010,
		SLGW_ACT_HOLD = 3'b100
	} slgw_act_e;

endpackage

// *** verification/slgw_chk.sv ***
// slgw_chk: port-level assertions for slgw_top, bound into every instance
// assumes one clock domain; config is tracked by snooping completed apb writes
`timescale 1ns/1ps
module slgw_chk #(
	parameter logic [slgw_pkg::LED_CNT_W-1:0] LED_PULSE_CYC = 24'h000014
) (
	input wire logic        MCLK_I,
	input wire logic        RST_I,
	input wire logic        CE_I,
	input wire logic        PSEL_I,
	input wire logic        PENABLE_I,
	input wire logic        PWRITE_I,
	input wire logic [7:0]  PADDR_I,
	input wire logic [31:0] PWDATA_I,
	input wire logic        PREADY_O,
	input wire logic        PSLVERR_O,
	input wire logic        LINK_UP_I,
	input wire logic        SPEED_100_I,
	input wire logic        FULL_DUPLEX_I,
	input wire logic        ANEG_BUSY_I,
	input wire logic        CROSSOVER_AUTO_STRAP_I,
	input wire logic        CROSSOVER_AUTO_EN_O,
	input wire logic [2:0]  GPIO_OUT_O,
	input wire logic [2:0]  GPIO_OE_O
);
	// ************
	// helper state
	// ************
	logic        armed, asleep, oe_q, in_off, held;
	logic [1:0]  sr;
	logic [2:0]  led;
	logic [23:0] off_cnt, on_cnt;
	wire         done = PSEL_I & PENABLE_I & PREADY_O & CE_I;
	wire         soft_reset_cmd_wr = done && PWRITE_I && armed && !asleep &&
	                       PADDR_I == slgw_pkg::ADDR_PWR_CTRL && PWDATA_I[slgw_pkg::PWR_SOFT_RESET_CMD_BIT];
	default clocking @(posedge MCLK_I); endclocking
	default disable iff (RST_I);
	// a write is only stored once armed and awake, so the snoop mirrors that gate
	always_ff @(posedge MCLK_I) begin
		if (RST_I) begin
			armed <= 1'b0;
			asleep <= 1'b0;
			led <= 3'h0;
		end else if (done && !PWRITE_I) begin
			armed <= 1'b1;
		end else if (done && asleep) begin
			asleep <= 1'b0;
			armed <= 1'b0;
		end else if (done && armed && PADDR_I == slgw_pkg::ADDR_GPIO_CFG) begin
			led <= PWDATA_I[10:8];
		end else if (done && armed && PADDR_I == slgw_pkg::ADDR_PWR_CTRL) begin
			asleep <= PWDATA_I[0] && !soft_reset_cmd_wr;
			armed <= !soft_reset_cmd_wr;
			led <= soft_reset_cmd_wr ? 3'h0 : led;
		end
	end
	always_ff @(posedge MCLK_I) begin
		oe_q <= GPIO_OE_O[1];
		// soft reset drops the crossover enable for one cycle after it lands
		sr <= {sr[0], soft_reset_cmd_wr};
		if (RST_I || !LINK_UP_I || !led[1]) begin
			in_off <= 1'b0;
			held <= 1'b0;
		end else if (oe_q && !GPIO_OE_O[1]) begin
			in_off <= 1'b1;
			held <= 1'b0;
			off_cnt <= 24'h000001;
		end else if (!GPIO_OE_O[1]) begin
			off_cnt <= off_cnt + 24'h000001;
		end else if (!oe_q && in_off) begin
			in_off <= 1'b0;
			held <= 1'b1;
			on_cnt <= 24'h000001;
		end else begin
			on_cnt <= on_cnt + 24'h000001;
		end
	end
	// ************
	// properties
	// ************
	sequence s_spd;
		(led[0] && $stable({LINK_UP_I, SPEED_100_I, ANEG_BUSY_I})) [*5];
	endsequence
	sequence s_dup;
		(led[2] && $stable({LINK_UP_I, FULL_DUPLEX_I})) [*5];
	endsequence
	property p_ready;
		PSEL_I && !PENABLE_I && CE_I |=> PREADY_O;
	endproperty
	property p_rdy_pulse;
		PREADY_O |=> !PREADY_O;
	endproperty
	property p_slverr;
		done && PADDR_I > slgw_pkg::ADDR_LINK_STAT |-> PSLVERR_O;
	endproperty
	property p_xover;
		$stable(CROSSOVER_AUTO_STRAP_I) [*5] ##0 sr == 2'b00 |-> CROSSOVER_AUTO_EN_O == CROSSOVER_AUTO_STRAP_I;
	endproperty
	property p_led_od;
		(GPIO_OUT_O & led & $past(led, 2)) == 3'h0;
	endproperty
	property p_speed;
		s_spd |-> GPIO_OE_O[0] == (LINK_UP_I && SPEED_100_I && !ANEG_BUSY_I);
	endproperty
	property p_duplex;
		s_dup |-> GPIO_OE_O[2] == (LINK_UP_I && FULL_DUPLEX_I);
	endproperty
	property p_linkdn;
		(led[1] && !LINK_UP_I) [*4] |-> !GPIO_OE_O[1];
	endproperty
	property p_off_len;
		$rose(GPIO_OE_O[1]) && in_off |-> off_cnt == LED_PULSE_CYC;
	endproperty
	property p_on_len;
		$fell(GPIO_OE_O[1]) && held && LINK_UP_I |-> on_cnt >= LED_PULSE_CYC;
	endproperty
	a_ready: assert property (p_ready) else $error("no ready after setup");
	a_rdy_pulse: assert property (p_rdy_pulse) else $error("ready too long");
	a_slverr: assert property (p_slverr) else $error("unmapped access no error");
	a_xover: assert property (p_xover) else $error("crossover enable wrong");
	a_led_od: assert property (p_led_od) else $error("led pin driven high");
	a_speed: assert property (p_speed) else $error("speed led wrong");
	a_duplex: assert property (p_duplex) else $error("duplex led wrong");
	a_linkdn: assert property (p_linkdn) else $error("link led on without link");
	a_off_len: assert property (p_off_len) else $error("off pulse length wrong");
	a_on_len: assert property (p_on_len) else $error("on time too short");
endmodule

bind slgw_top slgw_chk #(.LED_PULSE_CYC(LED_PULSE_CYC)) u_chk (
	.MCLK_I(MCLK_I), .RST_I(RST_I), .CE_I(CE_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
	.PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PREADY_O(PREADY_O),
	.PSLVERR_O(PSLVERR_O), .LINK_UP_I(LINK_UP_I), .SPEED_100_I(SPEED_100_I),
	.FULL_DUPLEX_I(FULL_DUPLEX_I), .ANEG_BUSY_I(ANEG_BUSY_I), .CROSSOVER_AUTO_STRAP_I(CROSSOVER_AUTO_STRAP_I),
	.CROSSOVER_AUTO_EN_O(CROSSOVER_AUTO_EN_O), .GPIO_OUT_O(GPIO_OUT_O), .GPIO_OE_O(GPIO_OE_O)
);

// *** verification/slgw_pins.sv ***
// slgw_pins: board side of the gpio/led and wake pins
// assumes pull-ups on every line; released lines read high
`timescale 1ns/1ps
module slgw_pins (
	input  wire logic [2:0] gpio_out_i,
	input  wire logic [2:0] gpio_oe_i,
	input  wire logic [2:0] ext_val_i,
	input  wire logic [2:0] ext_en_i,
	input  wire logic       wake_out_i,
	input  wire logic       wake_oe_i,
	output logic      [2:0] pin_o,
	output logic            wake_pin_o
);
	// a contention between chip and board is not modelled; the bench never drives an output pin
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			pin_o[i] = gpio_oe_i[i] ? gpio_out_i[i] : (ext_en_i[i] ? ext_val_i[i] : 1'b1);
		end
		wake_pin_o = wake_oe_i ? wake_out_i : 1'b1;
	end
endmodule

// *** verification/test_slgw_top.sv ***
// test_slgw_top: directed bench for slgw_top driven over apb
// assumes slgw_chk is bound in and the led pulse is shortened to 20 cycles
`timescale 1ns/1ps
module test_slgw_top;
	// ************
	// wiring
	// ************
	logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
	logic        link = 1'b0, spd = 1'b0, fdx = 1'b0, aneg = 1'b0, act = 1'b0, wev = 1'b0, strap = 1'b1;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rdat;
	logic [2:0]  ext_v = 3'h0, ext_e = 3'h0, gout, goe, pin;
	logic        pready, pslverr, rerr, wout, woe, xen, irq, wpin;
	logic [6:0]  tab [4] = '{7'b1110_000, 7'b1000_101, 7'b1101_101, 7'b0110_111};
	int          err_total = 0, compares = 0, cyc = 0, n;
	slgw_top #(.LED_PULSE_CYC(24'h000014)) DUT (
		.MCLK_I(clk), .RST_I(rst), .CE_I(1'b1), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
		.PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
		.LINK_UP_I(link), .SPEED_100_I(spd), .FULL_DUPLEX_I(fdx), .ANEG_BUSY_I(aneg), .ACTIVITY_I(act),
		.WAKE_EVENT_I(wev), .CROSSOVER_AUTO_STRAP_I(strap), .GPIO_IN_I(pin), .GPIO_OUT_O(gout),
		.GPIO_OE_O(goe), .WAKE_INDICATOR_OUT_O(wout), .WAKE_INDICATOR_OE_O(woe),
		.CROSSOVER_AUTO_EN_O(xen), .IRQ_O(irq)
	);
	slgw_pins u_pins (.gpio_out_i(gout), .gpio_oe_i(goe), .ext_val_i(ext_v), .ext_en_i(ext_e),
		.wake_out_i(wout), .wake_oe_i(woe), .pin_o(pin), .wake_pin_o(wpin));
	always #2.5 clk = ~clk;
	// ************
	// shared tasks
	// ************
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD %0t seen %h want %h", $time, seen, exp);
		end
	endtask
	task automatic tick(input int k);
		repeat (k) @(posedge clk);
	endtask
	// release then let an edge pass so the next setup never lands in the same step
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		// no wait-state budget here: only the bench timeout ends a stuck transfer
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
		@(posedge clk);
	endtask
	task automatic pulse_wake();
		wev <= 1'b1;
		tick(3);
		wev <= 1'b0;
		tick(5);
	endtask
	task automatic run(input logic lv);
		n = 0;
		while (pin[1] === lv && n < 200) begin
			@(posedge clk);
			n++;
		end
	endtask
	// ************
	// scenarios
	// ************
	task automatic t_regs();
		apb(1'b1, slgw_pkg::ADDR_GPIO_CFG, 32'h7);
		apb(1'b0, slgw_pkg::ADDR_IRQ_STATUS, 32'h0);
		chk(rdat, 32'h4);
		apb(1'b0, slgw_pkg::ADDR_GPIO_CFG, 32'h0);
		chk(rdat, 32'h0);
		apb(1'b1, slgw_pkg::ADDR_IRQ_STATUS, 32'h4);
		apb(1'b0, slgw_pkg::ADDR_IRQ_STATUS, 32'h0);
		chk(rdat, 32'h0);
		apb(1'b0, slgw_pkg::ADDR_BYTE_TEST, 32'h0);
		chk(rdat, slgw_pkg::BYTE_TEST_VALUE);
		apb(1'b0, 8'h40, 32'h0);
		chk({rdat[30:0], rerr}, 32'h1);
		$display("regs done");
	endtask
	task automatic t_strap();
		for (int v = 0; v < 2; v++) begin
			strap <= v[0];
			tick(6);
			chk(32'(xen), 32'(v[0]));
		end
		$display("strap done");
	endtask
	task automatic t_gpio();
		apb(1'b1, slgw_pkg::ADDR_GPIO_CFG, 32'h17);
		apb(1'b1, slgw_pkg::ADDR_GPIO_DATA, 32'h6);
		tick(2);
		chk(32'({goe, pin}), 32'h3E);
		apb(1'b1, slgw_pkg::ADDR_GPIO_DATA, 32'h1);
		tick(2);
		chk(32'({goe, pin}), 32'h31);
		apb(1'b1, slgw_pkg::ADDR_GPIO_CFG, 32'h0);
		ext_e <= 3'h7;
		ext_v <= 3'h5;
		tick(4);
		apb(1'b0, slgw_pkg::ADDR_GPIO_DATA, 32'h0);
		chk(rdat, 32'h5);
		ext_e <= 3'h0;
		$display("gpio done");
	endtask
	task automatic t_wake();
		apb(1'b1, slgw_pkg::ADDR_IRQ_MASK, 32'h0);
		apb(1'b1, slgw_pkg::ADDR_WAKE_CFG, 32'h3);
		pulse_wake();
		chk(32'({woe, wout, irq}), 32'h6);
		apb(1'b1, slgw_pkg::ADDR_IRQ_MASK, 32'h1);
		tick(2);
		chk(32'(irq), 32'h1);
		apb(1'b1, slgw_pkg::ADDR_IRQ_STATUS, 32'h1);
		tick(2);
		chk(32'(irq), 32'h0);
		apb(1'b1, slgw_pkg::ADDR_WAKE_CFG, 32'hD);
		tick(2);
		chk(32'({woe, wpin}), 32'h1);
		apb(1'b1, slgw_pkg::ADDR_PWR_CTRL, 32'h1);
		pulse_wake();
		chk(32'({woe, wout, wpin}), 32'h4);
		apb(1'b0, slgw_pkg::ADDR_LINK_STAT, 32'h0);
		chk(32'(rdat[slgw_pkg::LS_ASLEEP_BIT]), 32'h1);
		apb(1'b1, slgw_pkg::ADDR_BYTE_TEST, 32'h0);
		apb(1'b1, slgw_pkg::ADDR_IRQ_MASK, 32'h0);
		apb(1'b0, slgw_pkg::ADDR_IRQ_STATUS, 32'h0);
		chk({rdat[30:0], irq}, 32'hB);
		apb(1'b0, slgw_pkg::ADDR_LINK_STAT, 32'h0);
		chk(32'(rdat[slgw_pkg::LS_ASLEEP_BIT]), 32'h0);
		$display("wake done");
	endtask
	task automatic t_led();
		apb(1'b1, slgw_pkg::ADDR_GPIO_CFG, 32'h707);
		apb(1'b1, slgw_pkg::ADDR_GPIO_DATA, 32'h7);
		for (int i = 0; i < 4; i++) begin
			{link, spd, fdx, aneg} <= tab[i][6:3];
			tick(6);
			chk(32'(pin), 32'(tab[i][2:0]));
			chk(32'({gout, goe}), 32'({3'h0, ~tab[i][2:0]}));
		end
		$display("led done");
	endtask
	task automatic t_blink();
		{link, spd, fdx, aneg} <= 4'b1000;
		tick(6);
		act <= 1'b1;
		run(1'b0);
		run(1'b1);
		chk(n, 20);
		run(1'b0);
		chk(32'(n >= 20), 32'h1);
		act <= 1'b0;
		tick(60);
		chk(32'(pin[1]), 32'h0);
		$display("blink done");
	endtask
	// soft reset must clear the config and disarm writes again, like the pin reset
	task automatic t_soft_reset_cmd();
		apb(1'b1, slgw_pkg::ADDR_PWR_CTRL, 32'h2);
		apb(1'b1, slgw_pkg::ADDR_GPIO_CFG, 32'h7);
		apb(1'b0, slgw_pkg::ADDR_GPIO_CFG, 32'h0);
		chk(rdat, 32'h0);
		chk(32'(goe), 32'h0);
		$display("soft_reset_cmd done");
	endtask
	// ************
	// run control
	// ************
	task automatic end_of_test();
		$display("compares %0d err_total %0d", compares, err_total);
		if (err_total == 0 && compares > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			end_of_test();
		end
	end
	initial begin
		tick(6);
		chk(32'({pready, irq, goe, gout, wout}), 32'h0);
		rst <= 1'b0;
		@(posedge clk);
		t_regs();
		t_strap();
		t_gpio();
		t_wake();
		t_led();
		t_blink();
		t_soft_reset_cmd();
		end_of_test();
	end
endmodule

// *** verilog/slgw_blink.sv ***
// slgw_blink: link/activity blinker, 80 ms off then at least 80 ms on
// assumes activity is a level or pulse synchronous to clk_i
`timescale 1ns/1ps
module slgw_blink #(
	parameter logic [slgw_pkg::LED_CNT_W-1:0] PULSE_CYC = slgw_pkg::LED_CNT_W'(slgw_pkg::LED_PULSE_CYC)
) (
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic ce_i,
	slgw_led_if.blink lnk
);
	slgw_pkg::slgw_act_e                state;
	logic [slgw_pkg::LED_CNT_W-1:0]     cnt;
	logic                               pend;
	logic                               done;

	assign done = (cnt == PULSE_CYC - slgw_pkg::LED_CNT_W'(1));

	// activity seen during the on-hold is remembered so it blinks afterward
	always_ff @(posedge clk_i) begin
		if (rst_i || !lnk.link_up) begin
			pend <= 1'b0;
		end else if (ce_i) begin
			if (state == slgw_pkg::SLGW_ACT_HOLD && lnk.activity) begin
				pend <= 1'b1;
			end else if (state != slgw_pkg::SLGW_ACT_HOLD) begin
				pend <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || !lnk.link_up) begin
			state       <= slgw_pkg::SLGW_ACT_IDLE;
			cnt         <= '0;
			lnk.led_off <= 1'b0;
		end else if (ce_i) begin
			case (state)
				slgw_pkg::SLGW_ACT_IDLE: begin
					cnt <= '0;
					if (lnk.activity) begin
						state       <= slgw_pkg::SLGW_ACT_OFF; // RL14
						lnk.led_off <= 1'b1;
					end
				end
				slgw_pkg::SLGW_ACT_OFF: begin
					cnt <= cnt + slgw_pkg::LED_CNT_W'(1);
					if (done) begin
						state       <= slgw_pkg::SLGW_ACT_HOLD; // RL15
						lnk.led_off <= 1'b0;
						cnt         <= '0;
					end
				end
				slgw_pkg::SLGW_ACT_HOLD: begin
					cnt <= cnt + slgw_pkg::LED_CNT_W'(1);
					if (done) begin
						cnt <= '0;
						if (pend || lnk.activity) begin
							state       <= slgw_pkg::SLGW_ACT_OFF; // RL15
							lnk.led_off <= 1'b1;
						end else begin
							state <= slgw_pkg::SLGW_ACT_IDLE;
						end
					end
				end
				default: begin
					state       <= slgw_pkg::SLGW_ACT_IDLE;
					lnk.led_off <= 1'b0;
				end
			endcase
		end
	end
endmodule

// *** verilog/slgw_top.sv ***
// slgw_top: status led, gpio, wake indicator and strap logic with an apb register file
// assumes link status inputs come from the phy on MCLK_I; pins are synchronised here
//
// The address map and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
// Operation
// RL1: the reset input returns every flip-flop and register to its reset value.
// RL2: the host resets the device after power-up by the reset pin or the soft reset command.
// RL3: after a reset or sleep exit, writes are ignored until the first read.
// RL4: when enabled, a wake event asserts the wake indicator output.
// RL5: the wake indicator polarity and push-pull or open-drain drive are configurable.
// RL6: only a host write with select and strobe asserted leaves sleep; a wake event does not.
// RL7: in sleep, any host write wakes the device whatever its data.
// RL8: the host aims its waking write at the byte-order test register.
// RL9: crossover detection is on when the strap is high and off when it is low.
// RL10: each of the three gpio pins is push-pull output, open-drain output or input.
// RL11: a gpio pin in led function is always open-drain.
// RL12: the speed led is low at 100 Mb/s and high in negotiation, no link or 10 Mb/s.
// RL13: the link/activity led is low while a valid link is detected.
// RL14: activity with link up drives the link/activity led high for 80 ms.
// RL15: after each off pulse the led stays low at least 80 ms before another pulse.
// RL16: the duplex led is low in full duplex and high otherwise.
// RL17: in led function the led state overrides the gpio output data.
module slgw_top #(
	parameter logic [slgw_pkg::LED_CNT_W-1:0] LED_PULSE_CYC = slgw_pkg::LED_CNT_W'(slgw_pkg::LED_PULSE_CYC)
) (
	input  wire logic        MCLK_I,
	input  wire logic        RST_I,
	input  wire logic        CE_I,
	input  wire logic        PSEL_I,
	input  wire logic        PENABLE_I,
	input  wire logic        PWRITE_I,
	input  wire logic [7:0]  PADDR_I,
	input  wire logic [31:0] PWDATA_I,
	output logic      [31:0] PRDATA_O,
	output logic             PREADY_O,
	output logic             PSLVERR_O,
	input  wire logic        LINK_UP_I,
	input  wire logic        SPEED_100_I,
	input  wire logic        FULL_DUPLEX_I,
	input  wire logic        ANEG_BUSY_I,
	input  wire logic        ACTIVITY_I,
	input  wire logic        WAKE_EVENT_I,
	input  wire logic        CROSSOVER_AUTO_STRAP_I,
	input  wire logic [2:0]  GPIO_IN_I,
	output logic      [2:0]  GPIO_OUT_O,
	output logic      [2:0]  GPIO_OE_O,
	output logic             WAKE_INDICATOR_OUT_O,
	output logic             WAKE_INDICATOR_OE_O,
	output logic             CROSSOVER_AUTO_EN_O,
	output logic             IRQ_O
);
	// ************************************************************
	// pin synchronisers
	// ************************************************************
	logic [4:0] meta;
	logic [4:0] sync;
	logic [2:0] gpio_meta;
	logic [2:0] gpio_sync;
	logic       strap_sync;
	logic       wake_sync;
	logic       wake_prev;

	// a raw pin may be pulled by the internal pull-up, so it is treated as asynchronous
	always_ff @(posedge MCLK_I) begin
		if (RST_I) begin
			meta      <= 5'h00;
			sync      <= 5'h00;
			gpio_meta <= 3'h0;
			gpio_sync <= 3'h0;
		end else if (CE_I) begin
			meta      <= {WAKE_EVENT_I, ACTIVITY_I, CROSSOVER_AUTO_STRAP_I, FULL_DUPLEX_I, SPEED_100_I};
			sync      <= meta;
			gpio_meta <= GPIO_IN_I;
			gpio_sync <= gpio_meta;
		end
	end
	assign strap_sync = sync[2];
	assign wake_sync  = sync[4];

	// ************************************************************
	// registers
	// ************************************************************
	logic [10:0]              gpio_cfg;
	logic [2:0]               gpio_data;
	logic [3:0]               wake_cfg;
	logic                     asleep;
	logic                     write_armed;
	logic [slgw_pkg::IRQ_W-1:0] irq_status;
	logic [slgw_pkg::IRQ_W-1:0] irq_mask;
	logic                     wake_latched;
	logic                     link_prev;
	logic                     soft_rst;
	logic                     rst_all;

	logic setup;
	logic wr;
	logic rd;
	logic wr_ok;
	logic wr_dropped;
	logic wake_rise;
	logic link_chg;
	logic [slgw_pkg::IRQ_W-1:0] irq_set;
	logic [slgw_pkg::IRQ_W-1:0] irq_clr;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction

	function automatic logic mapped(input logic [7:0] a);
		mapped = hit(a, slgw_pkg::ADDR_GPIO_CFG) || hit(a, slgw_pkg::ADDR_GPIO_DATA) ||
		         hit(a, slgw_pkg::ADDR_WAKE_CFG) || hit(a, slgw_pkg::ADDR_PWR_CTRL) ||
		         hit(a, slgw_pkg::ADDR_BYTE_TEST) || hit(a, slgw_pkg::ADDR_IRQ_STATUS) ||
		         hit(a, slgw_pkg::ADDR_IRQ_MASK) || hit(a, slgw_pkg::ADDR_LINK_STAT);
	endfunction

	// soft reset acts like the pin reset one cycle later, except that it leaves the pin synchronisers running
	assign rst_all = RST_I || soft_rst; // RL1 RL2

	// apb: setup cycle, then a one-cycle access phase answered at once
	assign setup = PSEL_I && !PENABLE_I;
	assign wr    = PSEL_I && PENABLE_I && PWRITE_I && PREADY_O && CE_I;
	assign rd    = PSEL_I && PENABLE_I && !PWRITE_I && PREADY_O && CE_I;
	// a write in sleep is still honoured for waking, but stores nothing until read
	assign wr_ok      = wr && write_armed && !asleep; // RL3
	assign wr_dropped = wr && !wr_ok;
	assign wake_rise  = wake_sync && !wake_prev;
	assign link_chg   = LINK_UP_I != link_prev;
	assign irq_set    = {wr_dropped, link_chg, wake_rise};
	assign irq_clr    = (wr_ok && hit(PADDR_I, slgw_pkg::ADDR_IRQ_STATUS)) ?
	                    PWDATA_I[slgw_pkg::IRQ_W-1:0] : '0;

	always_ff @(posedge MCLK_I) begin
		if (rst_all) begin
			PREADY_O <= 1'b0;
		end else if (CE_I) begin
			PREADY_O <= setup;
		end
	end

	always_ff @(posedge MCLK_I) begin
		if (rst_all) begin
			PRDATA_O  <= slgw_pkg::REG_ZERO;
			PSLVERR_O <= 1'b0;
		end else if (CE_I && setup) begin
			PSLVERR_O <= !mapped(PADDR_I);
			case (PADDR_I)
				slgw_pkg::ADDR_GPIO_CFG:   PRDATA_O <= {21'h000000, gpio_cfg};
				slgw_pkg::ADDR_GPIO_DATA:  PRDATA_O <= {29'h00000000, gpio_sync};
				slgw_pkg::ADDR_WAKE_CFG:   PRDATA_O <= {28'h0000000, wake_cfg};
				slgw_pkg::ADDR_PWR_CTRL:   PRDATA_O <= {31'h00000000, asleep};
				slgw_pkg::ADDR_BYTE_TEST:  PRDATA_O <= slgw_pkg::BYTE_TEST_VALUE;
				slgw_pkg::ADDR_IRQ_STATUS: PRDATA_O <= {29'h00000000, irq_status};
				slgw_pkg::ADDR_IRQ_MASK:   PRDATA_O <= {29'h00000000, irq_mask};
				slgw_pkg::ADDR_LINK_STAT:  PRDATA_O <= {25'h0000000, asleep, write_armed, strap_sync,
				                                         ANEG_BUSY_I, sync[1], sync[0], LINK_UP_I};
				default:                   PRDATA_O <= slgw_pkg::REG_ZERO;
			endcase
		end
	end

	// writes stay blocked after reset and after sleep exit until a read completes
	always_ff @(posedge MCLK_I) begin
		if (rst_all) begin
			write_armed <= 1'b0; // RL3
		end else if (CE_I) begin
			if (rd) begin
				write_armed <= 1'b1; // RL3
			end else if (asleep && wr) begin
				write_armed <= 1'b0; // RL3
			end
		end
	end

	// only a write cycle leaves sleep; the wake event never does
	always_ff @(posedge MCLK_I) begin
		if (rst_all) begin
			asleep <= 1'b0;
		end else if (CE_I) begin
			if (asleep && wr) begin
				asleep <= 1'b0; // RL6 RL7
			end else if (wr_ok && hit(PADDR_I, slgw_pkg::ADDR_PWR_CTRL)) begin
				asleep <= PWDATA_I[slgw_pkg::PWR_SLEEP_BIT];
			end
		end
	end

	always_ff @(posedge MCLK_I) begin
		if (RST_I) begin
			soft_rst <= 1'b0;
		end else if (CE_I) begin
			soft_rst <= wr_ok && hit(PADDR_I, slgw_pkg::ADDR_PWR_CTRL) && PWDATA_I[slgw_pkg::PWR_SOFT_RESET_CMD_BIT]; // RL2
		end
	end

	always_ff @(posedge MCLK_I) begin
		if (rst_all) begin
			gpio_cfg  <= 11'h000;
			gpio_data <= 3'h0;
			wake_cfg  <= 4'h0;
			irq_mask  <= '0;
		end else if (CE_I && wr_ok) begin
			if (hit(PADDR_I, slgw_pkg::ADDR_GPIO_CFG)) begin
				gpio_cfg <= PWDATA_I[10:0]; // RL10
			end
			if (hit(PADDR_I, slgw_pkg::ADDR_GPIO_DATA)) begin
				gpio_data <= PWDATA_I[2:0];
			end
			if (hit(PADDR_I, slgw_pkg::ADDR_WAKE_CFG)) begin
				wake_cfg <= {1'b0, PWDATA_I[2:0]}; // RL5
			end
			if (hit(PADDR_I, slgw_pkg::ADDR_IRQ_MASK)) begin
				irq_mask <= PWDATA_I[slgw_pkg::IRQ_W-1:0];
			end
		end
	end

	// ************************************************************
	// events and interrupt
	// ************************************************************
	always_ff @(posedge MCLK_I) begin
		if (rst_all) begin
			wake_prev  <= 1'b0;
			link_prev  <= 1'b0;
			irq_status <= '0;
			IRQ_O      <= 1'b0;
		end else if (CE_I) begin
			wake_prev  <= wake_sync;
			link_prev  <= LINK_UP_I;
			// set wins over a write-one-to-clear in the same cycle
			irq_status <= (irq_status & ~irq_clr) | irq_set;
			IRQ_O      <= |(irq_status & irq_mask);
		end
	end

	// wake indicator holds until software writes the clear bit
	always_ff @(posedge MCLK_I) begin
		if (rst_all) begin
			wake_latched <= 1'b0;
		end else if (CE_I) begin
			if (wake_rise && wake_cfg[slgw_pkg::WAKE_EN_BIT]) begin
				wake_latched <= 1'b1; // RL4
			end else if (wr_ok && hit(PADDR_I, slgw_pkg::ADDR_WAKE_CFG) && PWDATA_I[slgw_pkg::WAKE_CLR_BIT]) begin
				wake_latched <= 1'b0;
			end
		end
	end

	always_ff @(posedge MCLK_I) begin
		if (rst_all) begin
			WAKE_INDICATOR_OUT_O <= 1'b0;
			WAKE_INDICATOR_OE_O  <= 1'b0;
		end else if (CE_I) begin
			if (wake_cfg[slgw_pkg::WAKE_OD_BIT]) begin
				// open-drain pulls low whenever the indicator level is low, i.e. wake_latched differs from the polarity bit
				WAKE_INDICATOR_OUT_O <= 1'b0; // RL5
				WAKE_INDICATOR_OE_O  <= wake_latched != wake_cfg[slgw_pkg::WAKE_POL_BIT];
			end else begin
				WAKE_INDICATOR_OUT_O <= wake_latched == wake_cfg[slgw_pkg::WAKE_POL_BIT]; // RL5
				WAKE_INDICATOR_OE_O  <= 1'b1;
			end
		end
	end

	always_ff @(posedge MCLK_I) begin
		if (rst_all) begin
			CROSSOVER_AUTO_EN_O <= 1'b0;
		end else if (CE_I) begin
			CROSSOVER_AUTO_EN_O <= strap_sync; // RL9
		end
	end

	// ************************************************************
	// leds and gpio pins
	// ************************************************************
	slgw_led_if lnk ();
	assign lnk.link_up  = LINK_UP_I;
	assign lnk.activity = sync[3];

	slgw_blink #(
		.PULSE_CYC (LED_PULSE_CYC)
	) u_blink (
		.clk_i (MCLK_I),
		.rst_i (rst_all),
		.ce_i  (CE_I),
		.lnk   (lnk)
	);

	logic [2:0] led_n;
	always_comb begin
		led_n[0] = !(LINK_UP_I && !ANEG_BUSY_I && sync[0]); // RL12
		led_n[1] = !LINK_UP_I || lnk.led_off;              // RL13 RL14
		led_n[2] = !(LINK_UP_I && sync[1]);                // RL16
	end

	always_ff @(posedge MCLK_I) begin
		if (rst_all) begin
			GPIO_OUT_O <= 3'h0;
			GPIO_OE_O  <= 3'h0;
		end else if (CE_I) begin
			for (int i = 0; i < slgw_pkg::GPIO_N; i++) begin
				if (gpio_cfg[slgw_pkg::GPIO_LED_LSB + i]) begin
					GPIO_OUT_O[i] <= 1'b0;      // RL11 RL17
					GPIO_OE_O[i]  <= !led_n[i]; // RL11 RL17
				end else if (!gpio_cfg[slgw_pkg::GPIO_OE_LSB + i]) begin
					GPIO_OUT_O[i] <= 1'b0;      // RL10
					GPIO_OE_O[i]  <= 1'b0;
				end else if (gpio_cfg[slgw_pkg::GPIO_OD_LSB + i]) begin
					GPIO_OUT_O[i] <= 1'b0;      // RL10
					GPIO_OE_O[i]  <= !gpio_data[i];
				end else begin
					GPIO_OUT_O[i] <= gpio_data[i]; // RL10
					GPIO_OE_O[i]  <= 1'b1;
				end
			end
		end
	end
endmodule
